// [core/dagen_consts.svh]
`ifndef DAGEN_CONSTS_SVH
`define DAGEN_CONSTS_SVH
// Data space geometry
`define DAGEN_ADDR_W        16
`define DAGEN_DATA_W        16
`define DAGEN_INSN_W        32
`define DAGEN_RAM_WORDS     3072
`define DAGEN_ROM_WORDS     12288
`define DAGEN_EXT_WORDS     16384
`define DAGEN_PER_WORDS     64
// Region bases
`define DAGEN_RAM_BASE      16'h0000
`define DAGEN_PER_BASE      16'h3800
`define DAGEN_ROM_BASE      16'h4000
`define DAGEN_EXT_BASE      16'hc000
// Write select codes above the pointer and step banks
`define DAGEN_SEL_XWRAP     5'h10
`define DAGEN_SEL_YWRAP     5'h11
`define DAGEN_SEL_WAIT      5'h12
// Wait configuration field
`define DAGEN_WAIT_LSB      0
`define DAGEN_WAIT_RST      16'h0000
`endif

// [core/dagen_pkg.sv]
package dagen_pkg;
    // Post-access pointer update modes
    typedef enum logic [2:0] {
        DAGEN_UPD_NONE = 3'h0,
        DAGEN_UPD_INC  = 3'h1,
        DAGEN_UPD_DEC  = 3'h2,
        DAGEN_UPD_STEP = 3'h3,
        DAGEN_UPD_WRAP = 3'h4,
        DAGEN_UPD_REV  = 3'h5,
        DAGEN_UPD_IMM  = 3'h6
    } dagen_upd_t;
    // Decoded region of a data address
    typedef enum logic [2:0] {
        DAGEN_REG_RAM  = 3'h0,
        DAGEN_REG_PER  = 3'h1,
        DAGEN_REG_ROM  = 3'h2,
        DAGEN_REG_EXT  = 3'h3,
        DAGEN_REG_RSV  = 3'h4
    } dagen_region_t;
    // Wait sequencer states, Gray ordered
    typedef enum logic [1:0] {
        DAGEN_ST_IDLE  = 2'b00,
        DAGEN_ST_CNT   = 2'b01,
        DAGEN_ST_PIN   = 2'b11
    } dagen_state_t;
endpackage : dagen_pkg

// [core/dagen_top.sv]
`timescale 1ns/1ps
`include "dagen_consts.svh"
module dagen_top #(
    parameter int AW = `DAGEN_ADDR_W
) (
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    input  wire logic                 x_acc_in,
    input  wire logic                 x_direct_in,
    input  wire logic [AW-1:0]        x_field_in,
    input  wire logic [1:0]           x_sel_in,
    input  wire dagen_pkg::dagen_upd_t x_upd_in,
    input  wire logic                 y_acc_in,
    input  wire logic                 y_direct_in,
    input  wire logic [AW-1:0]        y_field_in,
    input  wire logic [1:0]           y_sel_in,
    input  wire dagen_pkg::dagen_upd_t y_upd_in,
    input  wire logic [AW-1:0]        imm_in,
    input  wire logic                 wr_en_in,
    input  wire logic [4:0]           wr_sel_in,
    input  wire logic [AW-1:0]        wr_data_in,
    input  wire logic                 ext_wait_in,
    output logic      [AW-1:0]        x_addr_out,
    output logic      [AW-1:0]        y_addr_out,
    output logic                      x_valid_out,
    output logic                      y_valid_out,
    output dagen_pkg::dagen_region_t  x_region_out,
    output dagen_pkg::dagen_region_t  y_region_out,
    output logic                      stall_out
);
    import dagen_pkg::*;

    // ==========================================================
    // Address units
    // ==========================================================
    // wr_sel: 00-07 pointer, 08-0f step, 10/11 x/y wrap size, 12 wait config
    logic [AW-1:0] addr_pointer_reg [8];
    logic [AW-1:0] pointer_step_reg [8];
    logic [AW-1:0] x_wrap_size_reg;
    logic [AW-1:0] y_wrap_size_reg;
    logic [15:0]   wait_cfg_reg;
    logic          step_wr, xw_wr, yw_wr, wait_wr;
    logic [AW-1:0] new_ptr [8];
    logic          upd_en  [8];
    logic [AW-1:0] x_ptr;
    logic [AW-1:0] y_ptr;
    // Write strobe decode, one register per select code
    assign step_wr = wr_en_in & (wr_sel_in[4:3] == 2'b01);
    assign xw_wr   = wr_en_in & (wr_sel_in == `DAGEN_SEL_XWRAP);
    assign yw_wr   = wr_en_in & (wr_sel_in == `DAGEN_SEL_YWRAP);
    assign wait_wr = wr_en_in & (wr_sel_in == `DAGEN_SEL_WAIT);
    assign x_ptr   = addr_pointer_reg[{1'b0, x_sel_in}];
    assign y_ptr   = addr_pointer_reg[{1'b1, y_sel_in}];

    // Reverse bit order of a word
    function automatic logic [AW-1:0] dagen_rev(input logic [AW-1:0] v);
        logic [AW-1:0] r;
        r = '0;
        for (int i = 0; i < AW; i++)
            r[i] = v[AW-1-i];
        return r;
    endfunction : dagen_rev

    // Wrap update within a power-of-two block
    function automatic logic [AW-1:0] dagen_wrap(input logic [AW-1:0] p,
                                                 input logic [AW-1:0] s,
                                                 input logic [AW-1:0] m);
        logic [AW:0]   size;
        logic [AW:0]   blk;
        logic [AW:0]   low;
        logic [AW:0]   sum;
        size = {1'b0, m} + {{AW{1'b0}}, 1'b1};
        blk  = {{AW{1'b0}}, 1'b1};
        for (int i = 0; i < AW; i++)
            if (blk < size)
                blk = blk << 1;
        low = {1'b0, p} & (blk - 1'b1);
        sum = (low + {1'b0, s}) % size;
        return (p & ~(blk[AW-1:0] - 1'b1)) | sum[AW-1:0];
    endfunction : dagen_wrap

    // Per-pointer next value and update enable
    for (genvar g = 0; g < 8; g++) begin : g_ptr
        dagen_upd_t    mode;
        logic          hit;
        logic [AW-1:0] p;
        logic [AW-1:0] s;
        logic [AW-1:0] m;
        assign hit  = (g < 4) ? (x_acc_in & ~x_direct_in & (x_sel_in == 2'(g)))
                              : (y_acc_in & ~y_direct_in & (y_sel_in == 2'(g - 4)));
        assign mode = (g < 4) ? x_upd_in : y_upd_in;
        assign p    = addr_pointer_reg[g];
        assign s    = pointer_step_reg[g];
        assign m    = (g < 4) ? x_wrap_size_reg : y_wrap_size_reg;
        assign upd_en[g] = hit & ~stall_out & (mode != DAGEN_UPD_NONE);
        assign new_ptr[g] =
            (mode == DAGEN_UPD_INC)  ? p + 1'b1 :
            (mode == DAGEN_UPD_DEC)  ? p - 1'b1 :
            (mode == DAGEN_UPD_STEP) ? p + s :
            (mode == DAGEN_UPD_REV)  ? p + s :
            (mode == DAGEN_UPD_IMM)  ? p + imm_in :
            (mode == DAGEN_UPD_WRAP) ? dagen_wrap(p, s, m) : p;

        // Pointer and step storage
        always_ff @(posedge clk_in or negedge nrst_in)
        begin
            if (!nrst_in)
            begin
                addr_pointer_reg[g] <= '0;
                pointer_step_reg[g] <= '0;
            end
            else
            begin
                if (wr_en_in && wr_sel_in == 5'(g))
                    addr_pointer_reg[g] <= wr_data_in;
                else if (upd_en[g])
                    addr_pointer_reg[g] <= new_ptr[g];
                if (step_wr && wr_sel_in[2:0] == 3'(g))
                    pointer_step_reg[g] <= wr_data_in;
            end
        end
    end

    // ==========================================================
    // Address select and region decode
    // ==========================================================
    logic [AW-1:0] x_addr;
    logic [AW-1:0] y_addr;
    assign x_addr = x_direct_in ? x_field_in :
                    (x_upd_in == DAGEN_UPD_REV) ? dagen_rev(x_ptr) : x_ptr;
    assign y_addr = y_direct_in ? y_field_in :
                    (y_upd_in == DAGEN_UPD_REV) ? dagen_rev(y_ptr) : y_ptr;

    // Region of an address, same map for X and Y
    function automatic dagen_region_t dagen_dec(input logic [AW-1:0] a);
        if (a < `DAGEN_RAM_BASE + `DAGEN_RAM_WORDS)
            return DAGEN_REG_RAM;
        else if (a >= `DAGEN_PER_BASE && a < `DAGEN_PER_BASE + `DAGEN_PER_WORDS)
            return DAGEN_REG_PER;
        else if (a >= `DAGEN_ROM_BASE && a < `DAGEN_ROM_BASE + `DAGEN_ROM_WORDS)
            return DAGEN_REG_ROM;
        else if (a >= `DAGEN_EXT_BASE)
            return DAGEN_REG_EXT;
        else
            return DAGEN_REG_RSV;
    endfunction : dagen_dec

    dagen_region_t x_reg_w;
    dagen_region_t y_reg_w;
    logic          ext_acc;
    assign x_reg_w = dagen_dec(x_addr);
    assign y_reg_w = dagen_dec(y_addr);
    // Stretch the cycle in which the external address stands at the outputs
    assign ext_acc = (x_valid_out & (x_region_out == DAGEN_REG_EXT))
                   | (y_valid_out & (y_region_out == DAGEN_REG_EXT));

    // Registered address outputs, held while stalled
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            x_addr_out   <= '0;
            y_addr_out   <= '0;
            x_valid_out  <= 1'b0;
            y_valid_out  <= 1'b0;
            x_region_out <= DAGEN_REG_RAM;
            y_region_out <= DAGEN_REG_RAM;
        end
        else if (!stall_out)
        begin
            x_addr_out   <= x_addr;
            y_addr_out   <= y_addr;
            x_valid_out  <= x_acc_in;
            y_valid_out  <= y_acc_in;
            x_region_out <= x_reg_w;
            y_region_out <= y_reg_w;
        end
    end

    // ==========================================================
    // Configuration registers
    // ==========================================================
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            x_wrap_size_reg <= '0;
            y_wrap_size_reg <= '0;
            wait_cfg_reg    <= `DAGEN_WAIT_RST;
        end
        else if (xw_wr)
            x_wrap_size_reg <= wr_data_in;
        else if (yw_wr)
            y_wrap_size_reg <= wr_data_in;
        else if (wait_wr)
            wait_cfg_reg <= wr_data_in;
    end

    // ==========================================================
    // Wait sequencer
    // ==========================================================
    dagen_state_t st_reg;
    logic [2:0]   cnt_reg;
    logic [2:0]   wait_cnt;
    logic [1:0]   wsel;
    assign wsel     = wait_cfg_reg[`DAGEN_WAIT_LSB +: 2];
    assign wait_cnt = (wsel == 2'h0) ? 3'h0 : (wsel == 2'h1) ? 3'h1 :
                      (wsel == 2'h2) ? 3'h3 : 3'h7;
    // Stall while counting or while the external wait pin is held
    assign stall_out = (st_reg == DAGEN_ST_IDLE) ? (ext_acc & ((wait_cnt != 3'h0) | ext_wait_in))
                     : (st_reg == DAGEN_ST_CNT) ? 1'b1 : ext_wait_in;

    // Sequencer state
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_reg  <= DAGEN_ST_IDLE;
            cnt_reg <= 3'h0;
        end
        else
        begin
            case (st_reg)
                DAGEN_ST_IDLE:
                    if (ext_acc && wait_cnt > 3'h1)
                    begin
                        st_reg  <= DAGEN_ST_CNT;
                        cnt_reg <= wait_cnt - 3'h2;
                    end
                    else if (ext_acc && (wait_cnt != 3'h0 || ext_wait_in))
                        st_reg <= DAGEN_ST_PIN;
                DAGEN_ST_CNT:
                    if (cnt_reg == 3'h0)
                        st_reg <= DAGEN_ST_PIN;
                    else
                        cnt_reg <= cnt_reg - 3'h1;
                DAGEN_ST_PIN:
                    if (!ext_wait_in)
                        st_reg <= DAGEN_ST_IDLE;
                default:
                    st_reg <= DAGEN_ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_no_upd_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!x_acc_in && !y_acc_in && !wr_en_in) |=> $stable(addr_pointer_reg[1]))
        else $error("pointer changed without access");
    a_inc_next: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (upd_en[1] && x_upd_in == DAGEN_UPD_INC && !wr_en_in)
        |=> addr_pointer_reg[1] == $past(addr_pointer_reg[1]) + 16'h0001)
        else $error("increment wrong");
    a_step_add: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (upd_en[4] && y_upd_in == DAGEN_UPD_STEP && !wr_en_in)
        |=> addr_pointer_reg[4] == $past(addr_pointer_reg[4]) + $past(pointer_step_reg[4]))
        else $error("step add wrong");
    a_rev_addr: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (x_acc_in && !x_direct_in && x_upd_in == DAGEN_UPD_REV && !stall_out)
        |=> x_addr_out[0] == $past(x_ptr[AW-1]))
        else $error("reversed address wrong");
    a_direct_addr: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (y_acc_in && y_direct_in && !stall_out) |=> y_addr_out == $past(y_field_in))
        else $error("direct address wrong");
    a_ext_region: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (x_acc_in && x_addr >= 16'hc000) |-> x_reg_w == DAGEN_REG_EXT)
        else $error("external region miss");
    a_wait_seven: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st_reg == DAGEN_ST_IDLE && ext_acc && wsel == 2'h3 && !ext_wait_in) |->
        stall_out [*7] ##1 (stall_out == ext_wait_in))
        else $error("seven waits wrong");
    a_pin_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ext_acc && ext_wait_in) |-> stall_out)
        else $error("wait pin ignored");
endmodule : dagen_top

// [tb/dagen_mem_model.sv]
`timescale 1ns/1ps
// ============================================================
// External data memory side: stretches external accesses
module dagen_mem_model (
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    input  wire logic                     x_valid_in,
    input  wire logic                     y_valid_in,
    input  wire dagen_pkg::dagen_region_t x_region_in,
    input  wire dagen_pkg::dagen_region_t y_region_in,
    input  wire logic [7:0]               hold_in,
    output logic                          ext_wait_out
);
    import dagen_pkg::*;
    int   cnt_reg;
    logic seen_reg;
    logic ext_seen;
    // An external access is presented by either unit
    assign ext_seen = (x_valid_in && x_region_in == DAGEN_REG_EXT) ||
                      (y_valid_in && y_region_in == DAGEN_REG_EXT);
    // Hold the wait line for hold_in cycles on each new external access
    always @(negedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cnt_reg      <= 0;
            seen_reg     <= 1'b0;
            ext_wait_out <= 1'b0;
        end
        else
        begin
            seen_reg <= ext_seen;
            if (ext_seen && !seen_reg && hold_in > 0)
            begin
                cnt_reg      <= hold_in - 1;
                ext_wait_out <= 1'b1;
            end
            else if (cnt_reg > 0)
                cnt_reg <= cnt_reg - 1;
            else
                ext_wait_out <= 1'b0;        // Idle level is deasserted
        end
    end
endmodule : dagen_mem_model

// [tb/dagen_tb_top.sv]
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the data address generator
module dagen_tb_top;
    import dagen_pkg::*;
    logic          clk_in, nrst_in, x_acc_in, y_acc_in, x_direct_in, y_direct_in;
    logic [15:0]   x_field_in, y_field_in, imm_in, wr_data_in;
    logic [1:0]    x_sel_in, y_sel_in;
    dagen_upd_t    x_upd_in, y_upd_in;
    logic          wr_en_in, ext_wait_in, x_valid_out, y_valid_out, stall_out;
    logic [4:0]    wr_sel_in;
    logic [7:0]    ext_hold;
    logic          stall_q;
    logic [15:0]   x_addr_out, y_addr_out;
    dagen_region_t x_region_out, y_region_out;
    int            n_mismatch, checks, cnt;
    logic [15:0]   map_a [11] = '{16'h0000, 16'h0bff, 16'h0c00, 16'h3800, 16'h383f,
                                  16'h3840, 16'h4000, 16'h6fff, 16'h7000, 16'hc000, 16'hffff};
    dagen_region_t map_r [11] = '{DAGEN_REG_RAM, DAGEN_REG_RAM, DAGEN_REG_RSV, DAGEN_REG_PER,
                                  DAGEN_REG_PER, DAGEN_REG_RSV, DAGEN_REG_ROM, DAGEN_REG_ROM,
                                  DAGEN_REG_RSV, DAGEN_REG_EXT, DAGEN_REG_EXT};
    int            wait_n [4] = '{0, 1, 3, 7};
    // ============================================================
    // Design and far side
    dagen_top u_dagen_top (.clk_in(clk_in), .nrst_in(nrst_in), .x_acc_in(x_acc_in),
        .x_direct_in(x_direct_in), .x_field_in(x_field_in), .x_sel_in(x_sel_in),
        .x_upd_in(x_upd_in), .y_acc_in(y_acc_in), .y_direct_in(y_direct_in),
        .y_field_in(y_field_in), .y_sel_in(y_sel_in), .y_upd_in(y_upd_in), .imm_in(imm_in),
        .wr_en_in(wr_en_in), .wr_sel_in(wr_sel_in), .wr_data_in(wr_data_in),
        .ext_wait_in(ext_wait_in), .x_addr_out(x_addr_out), .y_addr_out(y_addr_out),
        .x_valid_out(x_valid_out), .y_valid_out(y_valid_out), .x_region_out(x_region_out),
        .y_region_out(y_region_out), .stall_out(stall_out));
    dagen_mem_model u_dagen_mem_model (.clk_in(clk_in), .nrst_in(nrst_in),
        .x_valid_in(x_valid_out), .y_valid_in(y_valid_out), .x_region_in(x_region_out),
        .y_region_in(y_region_out), .hold_in(ext_hold), .ext_wait_out(ext_wait_in));
    // Stall level that each rising edge acted on
    always @(posedge clk_in)
        stall_q <= stall_out;
    // ============================================================
    // Compare tasks and bus helpers
    task automatic cmp_val(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_val
    task automatic cmp_reg(input string n, input dagen_region_t e, input dagen_region_t g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0d seen %0d", n, e, g);
        end
    endtask : cmp_reg
    // Register write, one cycle strobe
    task automatic wr(input logic [4:0] s, input logic [15:0] d);
        @(negedge clk_in);
        wr_en_in = 1'b1;
        wr_sel_in = s;
        wr_data_in = d;
        @(negedge clk_in);
        wr_en_in = 1'b0;
    endtask : wr
    // One access on unit y or x; request stays up for back-to-back use
    task automatic op(input bit y, input logic d, input logic [15:0] f, input logic [1:0] s,
                      input dagen_upd_t u, input logic [15:0] ea, input dagen_region_t er);
        x_acc_in = !y;
        y_acc_in = y;
        {x_direct_in, y_direct_in} = {d, d};
        {x_field_in, y_field_in} = {f, f};
        {x_sel_in, y_sel_in} = {s, s};
        {x_upd_in, y_upd_in} = {u, u};
        @(negedge clk_in);
        while (stall_q === 1'b1)
            @(negedge clk_in);
        cmp_val("addr", ea, y ? y_addr_out : x_addr_out);
        cmp_val("valid", 16'h0001, {15'h0000, y ? y_valid_out : x_valid_out});
        cmp_reg("region", er, y ? y_region_out : x_region_out);
    endtask : op
    task automatic idle();
        x_acc_in = 1'b0;
        y_acc_in = 1'b0;
    endtask : idle
    // ============================================================
    // Scenarios
    task automatic t_steps();
        wr(5'h01, 16'h0010);
        wr(5'h09, 16'h0004);
        imm_in = 16'h0100;
        op(0, 0, 0, 1, DAGEN_UPD_INC, 16'h0010, DAGEN_REG_RAM);
        op(0, 0, 0, 1, DAGEN_UPD_DEC, 16'h0011, DAGEN_REG_RAM);
        op(0, 0, 0, 1, DAGEN_UPD_STEP, 16'h0010, DAGEN_REG_RAM);
        op(0, 0, 0, 1, DAGEN_UPD_IMM, 16'h0014, DAGEN_REG_RAM);
        idle();
        x_upd_in = DAGEN_UPD_INC;
        repeat (3) @(negedge clk_in);
        op(0, 0, 0, 1, DAGEN_UPD_NONE, 16'h0114, DAGEN_REG_RAM);
        idle();
    endtask : t_steps
    task automatic t_rev_wrap();
        wr(5'h01, 16'h0002);
        op(0, 0, 0, 1, DAGEN_UPD_REV, 16'h4000, DAGEN_REG_ROM);
        op(0, 0, 0, 1, DAGEN_UPD_NONE, 16'h0006, DAGEN_REG_RAM);
        idle();
        wr(5'h10, 16'h0007);
        wr(5'h01, 16'h0026);
        wr(5'h09, 16'h0004);
        op(0, 0, 0, 1, DAGEN_UPD_WRAP, 16'h0026, DAGEN_REG_RAM);
        op(0, 0, 0, 1, DAGEN_UPD_NONE, 16'h0022, DAGEN_REG_RAM);
        idle();
        wr(5'h04, 16'h0100);
        wr(5'h0c, 16'h0004);
        wr(5'h11, 16'h0003);
        op(1, 0, 0, 0, DAGEN_UPD_WRAP, 16'h0100, DAGEN_REG_RAM);
        op(1, 0, 0, 0, DAGEN_UPD_STEP, 16'h0100, DAGEN_REG_RAM);
        op(1, 0, 0, 0, DAGEN_UPD_NONE, 16'h0104, DAGEN_REG_RAM);
        idle();
    endtask : t_rev_wrap
    task automatic t_map();
        for (int i = 0; i < 11; i++)
        begin
            op(0, 1, map_a[i], 0, DAGEN_UPD_NONE, map_a[i], map_r[i]);
            op(1, 1, map_a[i], 0, DAGEN_UPD_NONE, map_a[i], map_r[i]);
        end
        idle();
    endtask : t_map
    // Count stretched cycles of one external access
    task automatic ext_acc(input logic [15:0] a, input int exp_n);
        op(0, 1, a, 0, DAGEN_UPD_NONE, a, DAGEN_REG_EXT);
        idle();
        cnt = 0;
        repeat (14)
        begin
            @(negedge clk_in);
            if (stall_q === 1'b1)
            begin
                cnt++;
                cmp_val("held_valid", 16'h0001, {15'h0000, x_valid_out});
            end
        end
        cmp_val("stall_cycles", exp_n[15:0], cnt[15:0]);
    endtask : ext_acc
    task automatic t_wait();
        for (int c = 0; c < 4; c++)
        begin
            wr(5'h12, c[15:0]);
            ext_acc(16'hc000, wait_n[c]);
        end
        wr(5'h12, 16'h0000);
        ext_hold = 3;
        ext_acc(16'hffff, 3);
        ext_hold = 0;
    endtask : t_wait
    // ============================================================
    // Closing, clock, watchdog and main sequence
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial
    begin
        #(3000 * 25);
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        {nrst_in, x_acc_in, y_acc_in, x_direct_in, y_direct_in, wr_en_in} = '0;
        {x_field_in, y_field_in, imm_in, wr_data_in, x_sel_in, y_sel_in, wr_sel_in} = '0;
        {x_upd_in, y_upd_in} = {DAGEN_UPD_NONE, DAGEN_UPD_NONE};
        {n_mismatch, checks, ext_hold} = '0;
        repeat (5) @(negedge clk_in);
        cmp_val("x_addr_rst", 16'h0000, x_addr_out);
        cmp_reg("y_region_rst", DAGEN_REG_RAM, y_region_out);
        cmp_val("flags_rst", 16'h0000, {13'h0000, x_valid_out, y_valid_out, stall_out});
        nrst_in = 1'b1;
        t_steps();
        t_rev_wrap();
        t_map();
        t_wait();
        report_and_stop();
    end
endmodule : dagen_tb_top
